// file: rtl/p2gpio_pkg.sv
// package: register map, reset values and field positions of the port-two gpio block
package p2gpio_pkg;
	localparam logic [15:0] ADDR_PIN_FUNCTION_SELECT = 16'hFFC9;
	localparam logic [15:0] ADDR_OPEN_DRAIN_SELECT   = 16'hFFCB;
	localparam logic [15:0] ADDR_PORT_TWO_DATA       = 16'hFFD5;
	localparam logic [15:0] ADDR_PORT_TWO_DIRECTION  = 16'hFFE5;
	// own registers for the port-one pull-up control bits
	localparam logic [15:0] ADDR_PORT_ONE_DIRECTION  = 16'hFFE4;
	localparam logic [15:0] ADDR_PORT_ONE_PULLUP     = 16'hFFE0;

	localparam logic [7:0] RST_PIN_FUNCTION_SELECT = 8'hC0;
	localparam logic [7:0] RST_OPEN_DRAIN_SELECT   = 8'h00;
	localparam logic [7:0] RST_PORT_TWO_DATA       = 8'h00;
	localparam logic [7:0] RST_PORT_TWO_DIRECTION  = 8'h00;
	localparam logic [7:0] RST_PORT_ONE            = 8'h00;
	localparam logic [7:0] PFS_FIXED_ONES          = 8'hC0;
	localparam logic [7:0] DIRECTION_READ_VALUE    = 8'hFF;
	localparam logic [7:0] UNMAPPED_READ_VALUE     = 8'h00;

	localparam int BIT_EXT_INT_FOUR_SELECT   = 0;
	localparam int BIT_UPDOWN_INPUT_SELECT   = 1;
	localparam int BIT_SERIAL_OUT_A_OFF      = 2;
	localparam int BIT_EXT_INT_ZERO_SELECT   = 3;
	localparam int BIT_CAPTURE_FILTER_ENABLE = 4;
	localparam int BIT_SERIAL_OUT_B_OFF      = 5;
	localparam int PULLUP_LOW_PIN            = 4;
endpackage

// file: rtl/p2gpio_pad.sv
// one port-two pad: gpio or alternate-input steering and buffer type
`timescale 1ns/1ps
`default_nettype none
module p2gpio_pad (
	input  wire logic i_clk,        // system clock
	input  wire logic i_rst,        // async reset, active high
	input  wire logic i_alt_sel,    // pin given to an alternate input
	input  wire logic i_dir,        // direction bit
	input  wire logic i_data,       // data latch bit
	input  wire logic i_od,         // open-drain select bit
	output logic      o_pad_out,    // registered pad drive level
	output logic      o_pad_oe      // registered pad output enable
);
	wire drive_en;
	wire out_nxt;
	wire oe_nxt;
	// alternate input pins never drive
	assign drive_en = i_dir & ~i_alt_sel;
	// open drain: drive only the low level, release for a high
	assign out_nxt  = i_od ? 1'b0 : i_data;
	assign oe_nxt   = drive_en & (~i_od | ~i_data);
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pad_out <= 1'b0;
			o_pad_oe  <= 1'b0;
		end else begin
			o_pad_out <= out_nxt;
			o_pad_oe  <= oe_nxt;
		end
	end
endmodule
`default_nettype wire

// file: rtl/p2gpio_top.sv
// top: wishbone registers and pin control for the port-two gpio block
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - port-one pins 7..4 pull up only when direction is 0 and pull-up bit 1.
// - all port-one pull-ups are off after reset.
// - data read returns the latch for general I/O bits whose direction is 1.
// - data read returns the live pin for bits whose direction is 0.
// - data latch resets to zero.
// - direction 1 drives the pin, direction 0 leaves it an input.
// - direction and latch act only while the pin is general I/O.
// - direction register is write-only and reads as all ones.
// - direction register resets to zero, all pins inputs.
// - function-select bits 7 and 6 read one and ignore writes.
// - function-select register resets to 0xC0.
// - bit 5 makes serial output b open drain when 1, push-pull when 0.
// - bit 2 makes serial output a open drain when 1, push-pull when 0.
// - bit 4 enables the capture input noise filter; resets to 0.
// - bit 3 routes port-four pin 3 to external interrupt zero.
// - bit 1 makes port-two pin 1 the up/down count input.
// - bit 0 makes port-two pin 0 interrupt four and converter trigger input.
// - open-drain bit n makes output pin n open drain, else push-pull.
// - open-drain select resets to zero.
module p2gpio_top
	import p2gpio_pkg::*;
#(
	parameter int PIN_COUNT = 8
) (
	input  wire logic        I_CLK,                    // 40 MHz system clock
	input  wire logic        I_RST,                    // async reset, active high
	input  wire logic        i_wb_cyc,                 // wishbone cycle
	input  wire logic        i_wb_stb,                 // wishbone strobe
	input  wire logic        i_wb_we,                  // wishbone write enable
	input  wire logic [15:0] i_wb_adr,                 // wishbone byte address
	input  wire logic [7:0]  i_wb_dat,                 // wishbone write data
	input  wire logic        i_wb_sel,                 // wishbone byte select
	output logic      [7:0]  o_wb_dat,                 // wishbone read data
	output logic             o_wb_ack,                 // wishbone acknowledge
	input  wire logic [PIN_COUNT-1:0] i_p2_pin,        // port-two pin levels
	output logic      [PIN_COUNT-1:0] o_p2_out,        // port-two drive levels
	output logic      [PIN_COUNT-1:0] o_p2_oe,         // port-two output enables
	input  wire logic        i_p43_pin,                // port-four pin 3 level
	output logic             o_p43_data,               // port-four pin 3 as plain input
	output logic             o_ext_int_zero_n,         // external interrupt zero input
	output logic             o_ext_int_four_n,         // external interrupt four input
	output logic             o_converter_trigger_n,    // converter trigger input
	output logic             o_updown_count,           // up/down count input
	output logic             o_capture_filter_enable,  // capture input filter on
	output logic             o_serial_out_a_highside_off, // serial out a open drain
	output logic             o_serial_out_b_highside_off, // serial out b open drain
	output logic      [3:0]  o_p1_pullup_on           // port-one pins 7..4 pull-up
);
	logic [7:0] pin_function_select_r;
	logic [7:0] open_drain_select_r;
	logic [PIN_COUNT-1:0] port_two_data_r;
	logic [PIN_COUNT-1:0] port_two_direction_r;
	logic [7:0] port_one_direction_r;
	logic [7:0] port_one_pullup_enable_r;
	logic [7:0] rd_nxt;

	wire req       = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	wire wr        = req & i_wb_we & i_wb_sel;
	wire hit_pfs   = i_wb_adr == ADDR_PIN_FUNCTION_SELECT;
	wire hit_od    = i_wb_adr == ADDR_OPEN_DRAIN_SELECT;
	wire hit_data  = i_wb_adr == ADDR_PORT_TWO_DATA;
	wire hit_dir   = i_wb_adr == ADDR_PORT_TWO_DIRECTION;
	wire hit_p1dir = i_wb_adr == ADDR_PORT_ONE_DIRECTION;
	wire hit_p1pu  = i_wb_adr == ADDR_PORT_ONE_PULLUP;

	wire ext_int_four_sel = pin_function_select_r[BIT_EXT_INT_FOUR_SELECT];
	wire updown_sel       = pin_function_select_r[BIT_UPDOWN_INPUT_SELECT];
	wire ext_int_zero_sel = pin_function_select_r[BIT_EXT_INT_ZERO_SELECT];

	// pins 1 and 0 leave gpio when their function bit is set
	wire [PIN_COUNT-1:0] alt_sel =
		{{(PIN_COUNT-2){1'b0}}, updown_sel, ext_int_four_sel};

	// alternate pins read the live pin, like inputs
	wire [PIN_COUNT-1:0] out_mask = port_two_direction_r & ~alt_sel;
	wire [PIN_COUNT-1:0] data_view =
		(port_two_data_r & out_mask) | (i_p2_pin & ~out_mask);

	wire [3:0] pullup_nxt =
		~port_one_direction_r[7:PULLUP_LOW_PIN] &
		port_one_pullup_enable_r[7:PULLUP_LOW_PIN];

	always_comb begin
		rd_nxt = UNMAPPED_READ_VALUE;
		if (hit_pfs) begin
			rd_nxt = pin_function_select_r | PFS_FIXED_ONES;
		end else if (hit_od) begin
			rd_nxt = open_drain_select_r;
		end else if (hit_data) begin
			rd_nxt = 8'(data_view);
		end else if (hit_dir) begin
			rd_nxt = DIRECTION_READ_VALUE;
		end else if (hit_p1dir) begin
			rd_nxt = DIRECTION_READ_VALUE;
		end else if (hit_p1pu) begin
			rd_nxt = port_one_pullup_enable_r;
		end
	end

	// single-cycle ack, every address answered
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 8'h00;
		end else begin
			o_wb_ack <= req;
			o_wb_dat <= req ? rd_nxt : 8'h00;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			pin_function_select_r <= RST_PIN_FUNCTION_SELECT;
			open_drain_select_r   <= RST_OPEN_DRAIN_SELECT;
			port_two_data_r       <= RST_PORT_TWO_DATA[PIN_COUNT-1:0];
			port_two_direction_r  <= RST_PORT_TWO_DIRECTION[PIN_COUNT-1:0];
		end else if (wr) begin
			if (hit_pfs) begin
				pin_function_select_r <= i_wb_dat | PFS_FIXED_ONES;
			end
			if (hit_od) begin
				open_drain_select_r <= i_wb_dat;
			end
			if (hit_data) begin
				port_two_data_r <= i_wb_dat[PIN_COUNT-1:0];
			end
			if (hit_dir) begin
				port_two_direction_r <= i_wb_dat[PIN_COUNT-1:0];
			end
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			port_one_direction_r     <= RST_PORT_ONE;
			port_one_pullup_enable_r <= RST_PORT_ONE;
		end else if (wr) begin
			if (hit_p1dir) begin
				port_one_direction_r <= i_wb_dat;
			end
			if (hit_p1pu) begin
				port_one_pullup_enable_r <= i_wb_dat;
			end
		end
	end

	// function outputs registered so every top output leaves a flip-flop
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			o_p1_pullup_on              <= 4'h0;
			o_p43_data                  <= 1'b0;
			o_ext_int_zero_n            <= 1'b1;
			o_ext_int_four_n            <= 1'b1;
			o_converter_trigger_n       <= 1'b1;
			o_updown_count              <= 1'b0;
			o_capture_filter_enable     <= 1'b0;
			o_serial_out_a_highside_off <= 1'b0;
			o_serial_out_b_highside_off <= 1'b0;
		end else begin
			o_p1_pullup_on <= pullup_nxt;
			// unselected interrupt and trigger inputs see an idle high level, the up/down count input a low
			o_p43_data       <= i_p43_pin;
			o_ext_int_zero_n <= ext_int_zero_sel ? i_p43_pin : 1'b1;
			o_ext_int_four_n <= ext_int_four_sel ? i_p2_pin[0] : 1'b1;
			o_converter_trigger_n <= ext_int_four_sel ? i_p2_pin[0] : 1'b1;
			o_updown_count   <= updown_sel ? i_p2_pin[1] : 1'b0;
			o_capture_filter_enable <=
				pin_function_select_r[BIT_CAPTURE_FILTER_ENABLE];
			o_serial_out_a_highside_off <=
				pin_function_select_r[BIT_SERIAL_OUT_A_OFF];
			o_serial_out_b_highside_off <=
				pin_function_select_r[BIT_SERIAL_OUT_B_OFF];
		end
	end

	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g++) begin : g_pad
			p2gpio_pad u_pad (
				.i_clk     (I_CLK),
				.i_rst     (I_RST),
				.i_alt_sel (alt_sel[g]),
				.i_dir     (port_two_direction_r[g]),
				.i_data    (port_two_data_r[g]),
				.i_od      (open_drain_select_r[g]),
				.o_pad_out (o_p2_out[g]),
				.o_pad_oe  (o_p2_oe[g])
			);
		end
	endgenerate
endmodule
`default_nettype wire

// file: tb/p2gpio_monitor.sv
// checker: bus handshake and alternate-input paths at the top ports
`timescale 1ns/1ps
`default_nettype none
module p2gpio_monitor
	import p2gpio_pkg::*;
(
	input wire logic        I_CLK,                 // clock
	input wire logic        I_RST,                 // reset
	input wire logic        i_wb_cyc,              // cycle
	input wire logic        i_wb_stb,              // strobe
	input wire logic        i_wb_we,               // write
	input wire logic [15:0] i_wb_adr,              // address
	input wire logic [7:0]  o_wb_dat,              // read data
	input wire logic        o_wb_ack,              // ack
	input wire logic [7:0]  i_p2_pin,              // pads
	input wire logic        i_p43_pin,             // p4 pin 3
	input wire logic        o_p43_data,            // p4 pin 3 input
	input wire logic        o_ext_int_zero_n,      // int zero
	input wire logic        o_ext_int_four_n,      // int four
	input wire logic        o_converter_trigger_n, // trigger
	input wire logic        o_updown_count         // up/down
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);
	wire rd_ack = o_wb_ack && !i_wb_we;
	ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("request not acked next cycle");
	ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	dir_ones_a: assert property (rd_ack && i_wb_adr == ADDR_PORT_TWO_DIRECTION |-> o_wb_dat == 8'hff)
		else $error("direction read not all ones");
	fixed_ones_a: assert property (rd_ack && i_wb_adr == ADDR_PIN_FUNCTION_SELECT |-> &o_wb_dat[7:6])
		else $error("function select top bits not one");
	p43_copy_a: assert property (!$past(I_RST) |-> o_p43_data == $past(i_p43_pin))
		else $error("plain input does not follow pin");
	int_zero_path_a: assert property (!o_ext_int_zero_n && !$past(I_RST) |-> !$past(i_p43_pin))
		else $error("interrupt zero low while pin high");
	int_four_path_a: assert property (!o_ext_int_four_n && !$past(I_RST) |-> !$past(i_p2_pin[0]))
		else $error("interrupt four low while pin high");
	trig_mirror_a: assert property (o_converter_trigger_n == o_ext_int_four_n)
		else $error("trigger differs from interrupt four");
	updown_path_a: assert property (o_updown_count && !$past(I_RST) |-> $past(i_p2_pin[1]))
		else $error("count input high while pin low");
	cover property (rd_ack && i_wb_adr == ADDR_PORT_TWO_DATA);
	cover property (!o_ext_int_four_n);
	cover property (o_updown_count);
endmodule
bind p2gpio_top p2gpio_monitor mon (.*);
`default_nettype wire

// file: tb/p2gpio_pins.sv
// far side: resolves port-two pad levels
`timescale 1ns/1ps
`default_nettype none
module p2gpio_pins (
	input  wire logic [7:0] i_out, // drive level
	input  wire logic [7:0] i_oe,  // drive enable
	input  wire logic [7:0] i_ext, // outside source
	output logic      [7:0] o_pin  // pad level
);
	// undriven pads follow the outside source, never the last driven level
	assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule
`default_nettype wire

// file: tb/p2gpio_bench.sv
// bench: random register traffic against a pad model
`timescale 1ns/1ps
`default_nettype none
module p2gpio_bench
	import p2gpio_pkg::*;
;
	logic I_CLK, I_RST, i_wb_cyc, i_wb_stb, i_wb_we, i_wb_sel, i_p43_pin, o_wb_ack;
	logic o_p43_data, o_ext_int_zero_n, o_ext_int_four_n, o_converter_trigger_n;
	logic o_updown_count, o_capture_filter_enable;
	logic o_serial_out_a_highside_off, o_serial_out_b_highside_off;
	logic [15:0] i_wb_adr;
	logic [7:0]  i_wb_dat, o_wb_dat, i_p2_pin, o_p2_out, o_p2_oe, ext, rdat, g;
	logic [3:0]  o_p1_pullup_on;
	logic [7:0]  v [6];
	int          n_mismatch, n_compared, seed;
	localparam logic [15:0] AD [6] = '{ADDR_PORT_TWO_DIRECTION, ADDR_PORT_TWO_DATA,
		ADDR_OPEN_DRAIN_SELECT, ADDR_PIN_FUNCTION_SELECT, ADDR_PORT_ONE_DIRECTION,
		ADDR_PORT_ONE_PULLUP};
	p2gpio_top dut (.*);
	p2gpio_pins pads (.i_out(o_p2_out), .i_oe(o_p2_oe), .i_ext(ext), .o_pin(i_p2_pin));
	function automatic logic [7:0] f_gp(input logic [7:0] f);
		return {6'h3f, ~f[1:0]}; // alternate pins never drive
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
		i_wb_we <= w;
		i_wb_adr <= a;
		i_wb_dat <= d;
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		// no answer latency assumed: a hung slave is left to the watchdog
		while (o_wb_ack !== 1'b1) begin
			@(posedge I_CLK);
		end
		rdat = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		@(posedge I_CLK);
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		I_CLK = 1'b0;
		forever #12.5 I_CLK = ~I_CLK;
	end
	initial begin
		#200000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		seed = 32'hc401;
		{I_RST, i_wb_sel, i_wb_cyc, i_wb_stb, i_wb_we, i_p43_pin} = 6'h30;
		{i_wb_adr, i_wb_dat, ext} = 32'h0000_005a;
		repeat (3) @(posedge I_CLK);
		I_RST <= 1'b0;
		@(posedge I_CLK);
		for (int r = 0; r < 2; r++) begin
			chk(o_p2_oe, 8'h00);
			chk(o_p1_pullup_on, 4'h0);
			bus(0, ADDR_PIN_FUNCTION_SELECT, 0);
			chk(rdat, 8'hc0);
			// a write with its byte lane off is acked but must not land
			i_wb_sel <= 1'b0;
			bus(1, ADDR_PIN_FUNCTION_SELECT, 8'h3f);
			i_wb_sel <= 1'b1;
			bus(0, ADDR_PIN_FUNCTION_SELECT, 0);
			chk(rdat, 8'hc0);
			bus(0, ADDR_OPEN_DRAIN_SELECT, 0);
			chk(rdat, 8'h00);
			bus(1, ADDR_PORT_TWO_DIRECTION, 8'hff);
			bus(0, ADDR_PORT_TWO_DATA, 0);
			chk(rdat, 8'h00);
			bus(0, 16'hff00, 0);
			chk(rdat, 8'h00);
			for (int k = 0; k < 40; k++) begin
				foreach (v[j])
					v[j] = $random(seed);
				if (k < 2)
					v[3] = k ? 8'h00 : 8'h3f;
				foreach (v[j])
					bus(1, AD[j], v[j]);
				ext <= $random(seed);
				i_p43_pin <= $random(seed);
				repeat (3) @(posedge I_CLK);
				g = f_gp(v[3]);
				chk(o_p2_oe, g & v[0] & ~(v[2] & v[1]));
				// drive level follows the latch; open drain forces it low
				chk(o_p2_out, v[1] & ~v[2]);
				chk(o_p1_pullup_on, ~v[4][7:4] & v[5][7:4]);
				chk(o_serial_out_b_highside_off, v[3][5]);
				chk(o_serial_out_a_highside_off, v[3][2]);
				chk(o_capture_filter_enable, v[3][4]);
				chk(o_ext_int_zero_n, v[3][3] ? i_p43_pin : 1'b1);
				chk(o_p43_data, i_p43_pin);
				chk(o_ext_int_four_n, v[3][0] ? ext[0] : 1'b1);
				chk(o_updown_count, v[3][1] & ext[1]);
				chk(o_converter_trigger_n, v[3][0] ? ext[0] : 1'b1);
				bus(0, ADDR_PORT_TWO_DATA, 0);
				chk(rdat, (g & v[0] & v[1]) | (~(g & v[0]) & ext));
				bus(0, ADDR_PIN_FUNCTION_SELECT, 0);
				chk(rdat, v[3] | 8'hc0);
				bus(0, ADDR_PORT_TWO_DIRECTION, 0);
				chk(rdat, 8'hff);
			end
			I_RST <= 1'b1;
			@(posedge I_CLK);
			I_RST <= 1'b0;
			@(posedge I_CLK);
		end
		end_sim();
	end
endmodule
`default_nettype wire
